// file: dtc_consts.svh
// Constants of the dual timer/counter pair
// Operation
// R1: Timer function counts once per machine cycle
// R2: Counter samples count pin once per cycle
// R3: Falling edge count appears next machine cycle
// R4: Count pin levels last one machine cycle
// R5: Run bit turns each counter on/off
// R6: Rollover sets flag; vectoring clears it
// R7: Count only when run and gate allow
// R8: Source bit selects pin edges or cycles
// R9: Mode register holds one nibble per counter
// R10: Mode 0 is 13-bit with 5-bit prescaler
// R11: Setting run bit keeps count registers
// R12: Mode 1 is a full 16-bit counter
// R13: Mode 2 reloads low byte from high
// R14: Counter 1 in mode 3 holds count
// R15: Split mode: low byte own, high byte timer
// R16: Counter 1 still runs baud clock in split
// R17: Software byte write beats an increment
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_OFF_RUNCTL 8'h88
`define DTC_OFF_MODE 8'h89
`define DTC_OFF_LO0 8'h8a
`define DTC_OFF_LO1 8'h8b
`define DTC_OFF_HI0 8'h8c
`define DTC_OFF_HI1 8'h8d
`define DTC_OFF_IST 8'h90
`define DTC_OFF_IMSK 8'h91
`define DTC_RUNCTL_OVF1 7
`define DTC_RUNCTL_RUN1 6
`define DTC_RUNCTL_OVF0 5
`define DTC_RUNCTL_RUN0 4
`define DTC_MODE_RST 8'h00
`define DTC_OSC_PER_MC 12
`define DTC_PH_LAST 4'hb
`define DTC_PH_SAMPLE 4'h9
`define DTC_PH_UPDATE 4'h4
`endif

// file: dtc_pkg.sv
// Types of the dual timer/counter pair
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_M13 = 2'b00,
		DTC_M16 = 2'b01,
		DTC_MRLD = 2'b10,
		DTC_MSPLIT = 2'b11
	} dtc_mode_type;
	typedef struct packed {
		logic gate;
		logic ext;
		dtc_mode_type mode;
	} dtc_ctl_type;
	typedef struct packed {
		logic ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} dtc_cnt_type;
endpackage : dtc_pkg

// file: dtc_pin_sampler.sv
// Pin synchroniser and machine-cycle falling-edge detector
`timescale 1ns/100ps
module dtc_pin_sampler (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	input wire logic samp_en,
	input wire logic upd_en,
	output logic level,
	output logic fall_ev
);
	logic s1_r;
	logic s2_r;
	logic smp_r;
	logic pend_r;
	wire fall_seen = samp_en & smp_r & ~s2_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			smp_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			// One sample per machine cycle; shorter levels may be missed
			if (samp_en) begin
				smp_r <= s2_r; // R2 R4
			end
			if (fall_seen) begin
				pend_r <= 1'b1; // R2
			end else if (upd_en) begin
				pend_r <= 1'b0;
			end
		end
	end
	assign level = s2_r;
	assign fall_ev = upd_en & pend_r; // R3
	a_fall_sample: assert property (@(posedge clk) disable iff (rst) fall_seen |=> pend_r) // R2
		else $error("falling edge not latched");
endmodule : dtc_pin_sampler

// file: dtc_timer_pair.sv
// Dual timer/counter pair with register port and interrupt
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "dtc_consts.svh"
module dtc_timer_pair (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	input wire logic gate_pin_zero,
	input wire logic gate_pin_one,
	input wire logic vector_ack_zero,
	input wire logic vector_ack_one,
	output logic overflow_flag_zero,
	output logic overflow_flag_one,
	output logic baud_tick,
	output logic irq
);
	logic [3:0] ph_r;
	logic run_bit_zero_r;
	logic run_bit_one_r;
	logic ovf0_r;
	logic ovf1_r;
	logic [7:0] mode_r;
	logic [7:0] lo0_r;
	logic [7:0] hi0_r;
	logic [7:0] lo1_r;
	logic [7:0] hi1_r;
	logic [1:0] ist_r;
	logic [1:0] msk_r;
	logic [7:0] rdata_r;
	logic irq_r;
	logic baud_r;
	logic [3:0] pin_lvl;
	logic [3:0] pin_ev;
	dtc_pkg::dtc_ctl_type ctl0;
	dtc_pkg::dtc_ctl_type ctl1;
	dtc_pkg::dtc_cnt_type c0;
	dtc_pkg::dtc_cnt_type c1;

	// Next value of one counter for one enable; split mode only steps the low byte
	function automatic dtc_pkg::dtc_cnt_type dtc_step(
		input dtc_pkg::dtc_mode_type md,
		input logic [7:0] hi,
		input logic [7:0] lo,
		input logic en
	);
		dtc_pkg::dtc_cnt_type r;
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0] s8;
		r.ovf = 1'b0;
		r.hi = hi;
		r.lo = lo;
		s13 = {1'b0, hi, lo[4:0]} + 14'h1;
		s16 = {1'b0, hi, lo} + 17'h1;
		s8 = {1'b0, lo} + 9'h1;
		if (en) begin
			case (md)
				dtc_pkg::DTC_M13: begin
					// Upper three low-byte bits are left alone
					r.hi = s13[12:5]; // R10
					r.lo = {lo[7:5], s13[4:0]}; // R10
					r.ovf = s13[13];
				end
				dtc_pkg::DTC_M16: begin
					r.hi = s16[15:8]; // R12
					r.lo = s16[7:0]; // R12
					r.ovf = s16[16];
				end
				dtc_pkg::DTC_MRLD: begin
					r.lo = s8[8] ? hi : s8[7:0]; // R13
					r.ovf = s8[8];
				end
				dtc_pkg::DTC_MSPLIT: begin
					r.lo = s8[7:0]; // R15
					r.ovf = s8[8];
				end
				default: begin
					r.ovf = 1'b0;
				end
			endcase
		end
		return r;
	endfunction : dtc_step

	// Machine cycle phase counter: every rate is derived from it
	wire ph_wrap = ph_r == `DTC_PH_LAST;
	wire mc_tick = ph_r == `DTC_PH_UPDATE;
	wire samp_en = ph_r == `DTC_PH_SAMPLE;

	wire [3:0] pins = {gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			dtc_pin_sampler u_smp (
				.clk(clk),
				.rst(rst),
				.pin(pins[gi]),
				.samp_en(samp_en),
				.upd_en(mc_tick),
				.level(pin_lvl[gi]),
				.fall_ev(pin_ev[gi])
			);
		end
	endgenerate

	// Register decode
	wire wr_runctl = wr & (addr == `DTC_OFF_RUNCTL);
	wire wr_mode = wr & (addr == `DTC_OFF_MODE);
	wire wr_lo0 = wr & (addr == `DTC_OFF_LO0);
	wire wr_lo1 = wr & (addr == `DTC_OFF_LO1);
	wire wr_hi0 = wr & (addr == `DTC_OFF_HI0);
	wire wr_hi1 = wr & (addr == `DTC_OFF_HI1);
	wire wr_ist = wr & (addr == `DTC_OFF_IST);
	wire wr_msk = wr & (addr == `DTC_OFF_IMSK);

	assign ctl0 = dtc_pkg::dtc_ctl_type'(mode_r[3:0]); // R9
	assign ctl1 = dtc_pkg::dtc_ctl_type'(mode_r[7:4]); // R9
	wire split0 = ctl0.mode == dtc_pkg::DTC_MSPLIT;
	wire hold1 = ctl1.mode == dtc_pkg::DTC_MSPLIT;

	// Count enables
	wire gate_ok0 = ~ctl0.gate | pin_lvl[2]; // R7
	wire gate_ok1 = ~ctl1.gate | pin_lvl[3]; // R7
	wire src0 = ctl0.ext ? pin_ev[0] : mc_tick; // R8 R1 R3
	wire src1 = ctl1.ext ? pin_ev[1] : mc_tick; // R8 R1 R3
	wire en0 = run_bit_zero_r & gate_ok0 & src0; // R5 R7
	wire en1 = run_bit_one_r & gate_ok1 & src1 & ~hold1; // R5 R7 R14
	wire en_h0 = split0 & run_bit_one_r & mc_tick; // R15

	assign c0 = dtc_step(ctl0.mode, hi0_r, lo0_r, en0);
	assign c1 = dtc_step(ctl1.mode, hi1_r, lo1_r, en1);
	wire [8:0] h0_sum = {1'b0, hi0_r} + 9'h1;
	wire ovf_h0 = en_h0 & h0_sum[8]; // R15

	// Software write wins over a same-cycle increment
	wire [7:0] lo0_nxt = wr_lo0 ? wdata : c0.lo; // R17
	wire [7:0] hi0_nxt = wr_hi0 ? wdata : (en_h0 ? h0_sum[7:0] : c0.hi); // R17 R15
	wire [7:0] lo1_nxt = wr_lo1 ? wdata : c1.lo; // R17
	wire [7:0] hi1_nxt = wr_hi1 ? wdata : c1.hi; // R17

	// In split mode the high byte of counter 0 owns flag one
	wire ev0 = c0.ovf; // R6
	wire ev1 = split0 ? ovf_h0 : c1.ovf; // R6 R16

	// Hardware set beats both a software write and a vector clear
	wire ovf0_base = wr_runctl ? wdata[`DTC_RUNCTL_OVF0] : ovf0_r;
	wire ovf1_base = wr_runctl ? wdata[`DTC_RUNCTL_OVF1] : ovf1_r;
	wire ovf0_nxt = ev0 | (ovf0_base & ~vector_ack_zero); // R6
	wire ovf1_nxt = ev1 | (ovf1_base & ~vector_ack_one); // R6
	wire run0_nxt = wr_runctl ? wdata[`DTC_RUNCTL_RUN0] : run_bit_zero_r; // R5 R11
	wire run1_nxt = wr_runctl ? wdata[`DTC_RUNCTL_RUN1] : run_bit_one_r; // R5 R11

	wire [1:0] ist_clr = wr_ist ? wdata[1:0] : 2'b00;
	wire [1:0] ist_nxt = {ev1, ev0} | (ist_r & ~ist_clr);
	wire [1:0] msk_nxt = wr_msk ? wdata[1:0] : msk_r;

	wire [7:0] runctl_rd = {ovf1_r, run_bit_one_r, ovf0_r, run_bit_zero_r, 4'h0};
	wire [7:0] rd_mux =
		(addr == `DTC_OFF_RUNCTL) ? runctl_rd :
		(addr == `DTC_OFF_MODE) ? mode_r :
		(addr == `DTC_OFF_LO0) ? lo0_r :
		(addr == `DTC_OFF_LO1) ? lo1_r :
		(addr == `DTC_OFF_HI0) ? hi0_r :
		(addr == `DTC_OFF_HI1) ? hi1_r :
		(addr == `DTC_OFF_IST) ? {6'h00, ist_r} :
		(addr == `DTC_OFF_IMSK) ? {6'h00, msk_r} : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_r <= 4'h0;
		end else begin
			ph_r <= ph_wrap ? 4'h0 : ph_r + 4'h1; // R1
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_bit_zero_r <= 1'b0;
			run_bit_one_r <= 1'b0;
			ovf0_r <= 1'b0;
			ovf1_r <= 1'b0;
			mode_r <= `DTC_MODE_RST;
		end else begin
			run_bit_zero_r <= run0_nxt;
			run_bit_one_r <= run1_nxt;
			ovf0_r <= ovf0_nxt;
			ovf1_r <= ovf1_nxt;
			if (wr_mode) begin
				mode_r <= wdata;
			end
		end
	end

	// Count bytes are not cleared by the run bit, only by reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lo0_r <= 8'h00;
			hi0_r <= 8'h00;
			lo1_r <= 8'h00;
			hi1_r <= 8'h00;
		end else begin
			lo0_r <= lo0_nxt; // R11
			hi0_r <= hi0_nxt;
			lo1_r <= lo1_nxt;
			hi1_r <= hi1_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ist_r <= 2'b00;
			msk_r <= 2'b00;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
			baud_r <= 1'b0;
		end else begin
			ist_r <= ist_nxt;
			msk_r <= msk_nxt;
			irq_r <= |(ist_r & msk_r);
			rdata_r <= rd ? rd_mux : 8'h00;
			baud_r <= c1.ovf; // R16
		end
	end

	assign rdata = rdata_r;
	assign overflow_flag_zero = ovf0_r;
	assign overflow_flag_one = ovf1_r;
	assign baud_tick = baud_r;
	assign irq = irq_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_mc_gap;
		!mc_tick [*8] ##1 !mc_tick [*3];
	endsequence

	a_mc_period: assert property (mc_tick |=> s_mc_gap ##1 mc_tick) // R1
		else $error("machine cycle tick not every 12 clocks");
	a_edge_update: assert property (pin_ev[0] |-> mc_tick) // R3
		else $error("pin count outside update phase");
	a_run_off: assert property ((!run_bit_zero_r && !wr_lo0) |=> $stable(lo0_r)) // R5
		else $error("stopped counter changed");
	a_flag_set: assert property (ev0 |=> ovf0_r) // R6
		else $error("overflow did not set flag");
	a_flag_ack: assert property ((vector_ack_one && !ev1) |=> !ovf1_r) // R6
		else $error("vector did not clear flag");
	a_gate_hold: assert property ((ctl0.gate && !pin_lvl[2] && !wr_lo0) |=> $stable(lo0_r)) // R7
		else $error("gated counter changed");
	a_src_timer: assert property ((en1 && !ctl1.ext) |-> mc_tick) // R8
		else $error("timer source off machine cycle");
	a_m0_upper: assert property ((ctl0.mode == dtc_pkg::DTC_M13 && !wr_lo0) |=> $stable(lo0_r[7:5])) // R10
		else $error("prescaler upper bits changed");
	a_run_keep: assert property ((wr_runctl && !run_bit_zero_r && !split0) |=> $stable({hi0_r, lo0_r})) // R11
		else $error("run write altered count");
	a_m16_carry: assert property ((ctl1.mode == dtc_pkg::DTC_M16 && en1 && lo1_r == 8'hff && !wr_hi1)
		|=> hi1_r == $past(hi1_r) + 8'h1) // R12
		else $error("16-bit carry missing");
	a_reload: assert property ((ctl0.mode == dtc_pkg::DTC_MRLD && ev0 && !wr_lo0) |=> lo0_r == $past(hi0_r)) // R13
		else $error("auto-reload wrong");
	a_m3_hold: assert property ((hold1 && !wr_lo1 && !wr_hi1) |=> $stable({hi1_r, lo1_r})) // R14
		else $error("counter one moved in mode 3");
	a_split_hi: assert property ((en_h0 && !wr_hi0) |=> hi0_r == $past(hi0_r) + 8'h1) // R15
		else $error("split high byte did not count");
	a_baud_run: assert property (c1.ovf |=> baud_tick) // R16
		else $error("baud tick missing");
	a_wr_prio: assert property (wr_hi0 |=> hi0_r == $past(wdata)) // R17
		else $error("write lost to increment");
	a_irq_level: assert property ((|(ist_r & msk_r)) |=> irq) // R6
		else $error("interrupt not raised");
endmodule : dtc_timer_pair

// file: dtc_pin_model.sv
// Far-side model of the count and gate pins
`timescale 1ns/100ps
module dtc_pin_model (
	input wire logic clk,
	output logic [1:0] cnt_pin,
	output logic [1:0] gate_pin
);
	initial begin
		cnt_pin = 2'b11;
		gate_pin = 2'b11;
	end
	// Low level held 23 clocks, high level at least 25, so every level is sampled at least once
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge clk) cnt_pin[ch] <= 1'b0;
			repeat (23) @(posedge clk);
			cnt_pin[ch] <= 1'b1;
			repeat (24) @(posedge clk);
		end
	endtask : pulse
	task automatic set_gate(input int ch, input logic v);
		@(posedge clk) gate_pin[ch] <= v;
	endtask : set_gate
endmodule : dtc_pin_model

// file: dual_timer_counter_pair_bench.sv
// Self-checking bench for the dual timer/counter pair
`timescale 1ns/100ps
module dual_timer_counter_pair_bench;
	localparam logic [7:0] a_ctl = 8'h88;
	localparam logic [7:0] a_mod = 8'h89;
	localparam logic [7:0] a_st = 8'h90;
	localparam logic [7:0] a_msk = 8'h91;
	logic clk, rst, wr, rd, ack0, ack1, ovf0, ovf1, baud, irq;
	logic [7:0] addr, wdata, rdata;
	logic [1:0] cnt_pin, gate_pin;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int baud_n = 0;
	dtc_pin_model pm (.clk(clk), .cnt_pin(cnt_pin), .gate_pin(gate_pin));
	dtc_timer_pair dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.count_pin_zero(cnt_pin[0]), .count_pin_one(cnt_pin[1]), .gate_pin_zero(gate_pin[0]),
		.gate_pin_one(gate_pin[1]), .vector_ack_zero(ack0), .vector_ack_one(ack1),
		.overflow_flag_zero(ovf0), .overflow_flag_one(ovf1), .baud_tick(baud), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	// Generous ceiling: the whole sequence needs well under 3000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			num_errors++;
			report_and_stop();
		end
	end
	// Only the second-counter scenario overflows counter one, so exactly one baud pulse is due
	always @(posedge clk) begin
		if (baud === 1'b1) begin
			baud_n <= baud_n + 1;
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask : rd_chk
	task automatic pre(input logic [7:0] sel, input logic [7:0] hi, input logic [7:0] lo);
		bus_wr(8'h8a + sel, lo);
		bus_wr(8'h8c + sel, hi);
	endtask : pre
	// Run window is exactly n cycles wide, so n/12 increments land in it whatever the phase
	task automatic run(input logic [7:0] tm, input logic [7:0] trun, input int n);
		bus_wr(a_mod, tm);
		bus_wr(a_st, 8'h03);
		bus_wr(a_ctl, trun);
		repeat (n - 2) @(posedge clk);
		bus_wr(a_ctl, 8'h00);
	endtask : run
	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		ack0 = 1'b0;
		ack1 = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd_chk(a_ctl, 8'h00);
		rd_chk(a_mod, 8'h00);
		rd_chk(8'h99, 8'h00);
		bus_wr(a_mod, 8'ha5);
		rd_chk(a_mod, 8'ha5);
		bus_wr(a_msk, 8'h01);
		pre(0, 8'hff, 8'hfe);
		run(8'h01, 8'h10, 36);
		rd_chk(8'h8a, 8'h01);
		rd_chk(8'h8c, 8'h00);
		rd_chk(a_st, 8'h01);
		chk({7'h00, irq}, 8'h01);
		bus_wr(a_st, 8'h01);
		repeat (2) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		$display("sixteen-bit mode done");
		pre(0, 8'hff, 8'hff);
		run(8'h00, 8'h10, 36);
		rd_chk(8'h8a, 8'he2);
		rd_chk(8'h8c, 8'h00);
		rd_chk(a_st, 8'h01);
		$display("prescaler mode done");
		pre(0, 8'ha0, 8'hfe);
		run(8'h02, 8'h10, 36);
		rd_chk(8'h8a, 8'ha1);
		rd_chk(8'h8c, 8'ha0);
		rd_chk(a_st, 8'h01);
		$display("reload mode done");
		pre(1, 8'hff, 8'hfe);
		run(8'h10, 8'h40, 36);
		rd_chk(8'h8b, 8'h01);
		rd_chk(8'h8d, 8'h00);
		rd_chk(a_st, 8'h02);
		$display("second counter done");
		pre(0, 8'hfe, 8'hfe);
		pre(1, 8'h12, 8'h77);
		run(8'h33, 8'h50, 36);
		rd_chk(8'h8a, 8'h01);
		rd_chk(8'h8c, 8'h01);
		rd_chk(8'h8b, 8'h77);
		rd_chk(a_st, 8'h03);
		$display("split mode done");
		pm.set_gate(0, 1'b0);
		pre(0, 8'h00, 8'h00);
		run(8'h09, 8'h10, 36);
		rd_chk(8'h8a, 8'h00);
		pm.set_gate(0, 1'b1);
		run(8'h09, 8'h10, 36);
		rd_chk(8'h8a, 8'h03);
		$display("gate done");
		pre(0, 8'h00, 8'h00);
		bus_wr(a_mod, 8'h05);
		bus_wr(a_ctl, 8'h10);
		pm.pulse(0, 3);
		repeat (48) @(posedge clk);
		bus_wr(a_ctl, 8'h00);
		rd_chk(8'h8a, 8'h03);
		$display("event count done");
		bus_wr(a_ctl, 8'ha0);
		@(negedge clk);
		chk({7'h00, ovf0}, 8'h01);
		chk({7'h00, ovf1}, 8'h01);
		@(posedge clk) ack0 <= 1'b1;
		@(posedge clk);
		ack0 <= 1'b0;
		ack1 <= 1'b1;
		@(negedge clk);
		chk({7'h00, ovf0}, 8'h00);
		chk({7'h00, ovf1}, 8'h01);
		@(posedge clk) ack1 <= 1'b0;
		@(negedge clk);
		chk({7'h00, ovf1}, 8'h00);
		chk(baud_n[7:0], 8'h01);
		$display("vector clear done");
		report_and_stop();
	end
endmodule : dual_timer_counter_pair_bench
